// file: sar_top.sv
/*
  Serial audio ingest and router: samples the audio bit clock, word select
  and four data lines, forms sample words (two-channel or time-division),
  routes lanes to two downstream ports and hands words to the link packer
  data-island words gated by blanking. Assumes blanking, protection and upstream surround
  inputs are on mclk; audio pins and the strap come from outside.
*/
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - The bit clock must run between 1 MHz and the lesser of half the pixel clock or 13 MHz, and capture works across that range.
// - Each of the four data lines carries two channels told apart by the shared word select level.
// - Out of reset audio goes out as data-island packets, only in video blanking.
// - With data islands off, audio rides frame bits: line A only, or A and B for the older receiver.
// - Surround with all four lines runs only under data-island transport.
// - Surround signalled from upstream switches this stage to surround over data islands by itself; here it takes effect only while data islands are already on.
// - With split-audio clear both ports carry the same audio, channel count set by link path control.
// - With split-audio set port 1 swaps pairs A/B with C/D while port 0 stays straight.
// - In stereo with split-audio set port 1 carries input C and port 0 input A; here only input A is handed on, and port 1 gets its words tagged as lane C.
// - Split-audio resets to the sampled splitter strap and software may overwrite it.
// - Time-division format takes a 256-bit word clock period as 4 slots of 64 or 8 of 32 bits.
// - Sample words of 16, 24 or 32 bits at 32 to 192 kHz are supported.
// - Data-island audio is marked for encryption when protection is on; frame-bit audio is not.
// - A data line switched to register GPIO mode is ignored as audio and read as a register I/O.
module sar_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [sar_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sar_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic audio_bit_clock_in,
  input wire logic audio_word_select_in,
  input wire logic audio_data_line_a,
  input wire logic audio_data_line_b,
  input wire logic audio_data_line_c,
  input wire logic audio_data_line_d,
  input wire logic splitter_strap,
  input wire logic video_blanking,
  input wire logic content_protect_active,
  input wire logic upstream_surround,
  output logic audio_valid,
  input wire logic audio_ready,
  output sar_pkg::sar_item_type audio_item
);

  function automatic logic [31:0] wl_mask(input logic [1:0] sel);
    wl_mask = (sel == sar_pkg::WL_16) ? 32'h0000FFFF :
              (sel == sar_pkg::WL_24) ? 32'h00FFFFFF : 32'hFFFFFFFF;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [1:0] first_lane(input logic [3:0] p);
    first_lane = p[0] ? 2'h0 : p[1] ? 2'h1 : p[2] ? 2'h2 : 2'h3;
  endfunction

  // Pin synchroniser: {strap, d, c, b, a, ws, bclk}
  logic [6:0] pin_meta_q;
  logic [6:0] pin_sync_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {splitter_strap, audio_data_line_d, audio_data_line_c,
                     audio_data_line_b, audio_data_line_a,
                     audio_word_select_in, audio_bit_clock_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Registers
  logic [sar_pkg::CFG_W-1:0] cfg_q;
  logic [sar_pkg::PATH_W-1:0] path_q;
  logic [3:0] gpio_q;
  logic [sar_pkg::ST_W-1:0] sts_q;
  logic [1:0] strap_cnt_q;
  logic bclk_prev_q, ws_prev_q, seen_q;
  logic [sar_pkg::PER_W-1:0] per_q;
  logic [3:0][31:0] shift_q;
  logic [3:0][31:0] hold_q;
  logic [2:0] hold_chan_q;
  logic [3:0] pend_q;
  logic [sar_pkg::TDM_POS_W-1:0] pos_q;

  // Mode decode
  wire logic split = cfg_q[sar_pkg::CFG_SPLIT];
  wire logic [1:0] wl_sel = cfg_q[sar_pkg::CFG_WL_LO +: 2];
  wire logic tdm = cfg_q[sar_pkg::CFG_TDM];
  wire logic tdm8 = cfg_q[sar_pkg::CFG_TDM8];
  wire logic di_mode = ~path_q[sar_pkg::PATH_DI_OFF];
  wire logic [1:0] ch_mode = path_q[sar_pkg::PATH_MODE_LO +: 2];
  wire logic legacy = path_q[sar_pkg::PATH_LEGACY];
  wire logic surround = di_mode & ((ch_mode == sar_pkg::CH_SURROUND) |
                        upstream_surround);
  wire logic [3:0] lanes_frame = legacy ? sar_pkg::LANES_AB
                                        : sar_pkg::LANES_A;
  wire logic [3:0] lanes_di = (ch_mode == sar_pkg::CH_FOUR) ?
                              sar_pkg::LANES_AB : sar_pkg::LANES_A;
  wire logic [3:0] lane_en = tdm ? sar_pkg::LANES_A :
                             surround ? sar_pkg::LANES_ALL :
                             di_mode ? lanes_di : lanes_frame;

  // Sampled pins; a line in register GPIO mode feeds no audio
  wire logic bclk_s = pin_sync_q[0];
  wire logic ws_s = pin_sync_q[1];
  wire logic [3:0] line_s = pin_sync_q[5:2];
  wire logic [3:0] line_bits = line_s & ~gpio_q;
  wire logic [3:0] lane_live = lane_en & ~gpio_q;
  wire logic strap_s = pin_sync_q[6];
  wire logic bclk_rise = bclk_s & ~bclk_prev_q;

  // Bit clock period check
  wire logic too_fast = bclk_rise & seen_q &
                        (per_q < sar_pkg::BCLK_MIN_CYC);
  wire logic too_slow = ~bclk_rise & seen_q &
                        (per_q == sar_pkg::BCLK_MAX_CYC);

  // Word boundaries
  wire logic ws_edge = bclk_rise & (ws_s != ws_prev_q);
  wire logic ws_start = bclk_rise & ws_s & ~ws_prev_q;
  wire logic [4:0] pos32 = pos_q[4:0];
  wire logic [5:0] pos64 = pos_q[5:0];
  wire logic slot_in32 = tdm8 ? 1'b1 : ~pos_q[5];
  wire logic slot_end = tdm8 ? (pos32 == sar_pkg::SLOT32_LAST)
                             : (pos64 == sar_pkg::SLOT64_LAST);
  wire logic [2:0] slot_idx = tdm8 ? pos_q[7:5] : {1'b0, pos_q[7:6]};
  wire logic i2s_end = ~tdm & ws_edge;
  wire logic tdm_end = tdm & bclk_rise & ~ws_start & slot_end;
  wire logic word_end = i2s_end | tdm_end;

  // Handing words to the buffer, one lane per cycle
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  sar_pkg::sar_item_type buf_in_item, buf_out_item;
  wire logic buf_in_valid = |pend_q;
  wire logic [1:0] lane_sel = first_lane(pend_q);
  wire logic buf_take = buf_in_valid & buf_in_ready;
  wire logic [3:0] lane_bit = 4'h1 << lane_sel;
  wire logic overrun = word_end & |pend_q;
  assign buf_in_item.lane_p0 = lane_sel;
  assign buf_in_item.lane_p1 = split ? (lane_sel ^ 2'h2)
                                     : lane_sel;
  assign buf_in_item.chan = hold_chan_q;
  assign buf_in_item.encrypt = di_mode & content_protect_active;
  assign buf_in_item.data = hold_q[lane_sel] & wl_mask(wl_sel);

  // Next shift values: MSB first into the low end
  logic [3:0][31:0] shift_d;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      shift_d[i] = {shift_q[i][30:0], line_bits[i]};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_prev_q <= 1'b0;
      ws_prev_q <= 1'b0;
      seen_q <= 1'b0;
      per_q <= '0;
    end else begin
      bclk_prev_q <= bclk_s;
      if (bclk_rise) begin
        ws_prev_q <= ws_s;
        per_q <= '0;
        seen_q <= 1'b1;
      end else if (too_slow) begin
        seen_q <= 1'b0;
      end else if (per_q != sar_pkg::BCLK_MAX_CYC) begin
        per_q <= per_q + 1'b1;
      end
    end
  end

  // Capture: two-channel shifts every lane, time-division only lane A
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= '0;
      pos_q <= '0;
    end else if (bclk_rise) begin
      pos_q <= ws_start ? '0 : pos_q + 1'b1;
      if (!tdm) begin
        shift_q <= shift_d;
      end else if (slot_in32) begin
        shift_q[0] <= shift_d[0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
      hold_chan_q <= '0;
      pend_q <= '0;
    end else if (word_end) begin
      hold_q <= shift_d;
      if (tdm && !slot_in32) begin
        hold_q[0] <= shift_q[0];
      end
      hold_chan_q <= tdm ? slot_idx : {2'h0, ws_prev_q};
      pend_q <= lane_live;
    end else if (buf_take) begin
      pend_q <= pend_q & ~lane_bit;
    end
  end

  sar_skid u_buf (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_item(buf_in_item),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_item(buf_out_item)
  );

  // Data-island words leave only in blanking; frame bits go any time
  wire logic gate_open = ~di_mode | video_blanking;
  assign buf_out_ready = gate_open & (~audio_valid | audio_ready);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      audio_valid <= 1'b0;
      audio_item <= '0;
    end else if (buf_out_valid && buf_out_ready) begin
      audio_valid <= 1'b1;
      audio_item <= buf_out_item;
    end else if (audio_ready) begin
      audio_valid <= 1'b0;
    end
  end

  // AXI4-Lite slave
  logic aw_have_q, w_have_q;
  logic [sar_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic aw_ok = aw_have_q | aw_take;
  wire logic w_ok = w_have_q | w_take;
  wire logic do_wr = aw_ok & w_ok & ~s_axi_bvalid;
  wire logic [sar_pkg::ADDR_W-1:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire logic [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
  wire logic [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
  wire logic wr_cfg = do_wr & (wa == sar_pkg::REG_AUDIO_CFG);
  wire logic wr_path = do_wr & (wa == sar_pkg::REG_PATH_CTL);
  wire logic wr_gpio = do_wr & (wa == sar_pkg::REG_GPIO_CFG);
  wire logic wr_sts = do_wr & (wa == sar_pkg::REG_STATUS);
  wire logic wr_hit = wr_cfg | wr_path | wr_gpio | wr_sts;
  wire logic aw_have_d = aw_ok & ~do_wr;
  wire logic w_have_d = w_ok & ~do_wr;
  wire logic bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);

  wire logic [31:0] cfg_wr = merge(32'(cfg_q), wd, ws);
  wire logic [31:0] path_wr = merge(32'(path_q), wd, ws);
  wire logic [31:0] gpio_wr = merge(32'(gpio_q), wd, ws);
  wire logic [31:0] sts_wr = merge(32'h0, wd, ws);
  wire logic [sar_pkg::ST_W-1:0] sts_clr =
    wr_sts ? sts_wr[sar_pkg::ST_W-1:0] : '0;
  wire logic [sar_pkg::ST_W-1:0] sts_set = {overrun | (buf_in_valid &
    ~buf_in_ready & word_end), too_fast, too_slow};
  wire logic strap_load = (strap_cnt_q == sar_pkg::STRAP_WAIT - 2'h1);

  // Register read mux
  wire logic [31:0] rd_sts = {26'h0, surround, di_mode, 1'b0, sts_q};
  wire logic [31:0] rd_gpio = {20'h0, line_s, 4'h0, gpio_q};
  wire logic [sar_pkg::ADDR_W-1:0] ra = s_axi_araddr;
  wire logic rd_hit = (ra == sar_pkg::REG_AUDIO_CFG) |
                      (ra == sar_pkg::REG_PATH_CTL) |
                      (ra == sar_pkg::REG_GPIO_CFG) |
                      (ra == sar_pkg::REG_STATUS);
  wire logic [31:0] rd_val =
    (ra == sar_pkg::REG_AUDIO_CFG) ? 32'(cfg_q) :
    (ra == sar_pkg::REG_PATH_CTL) ? 32'(path_q) :
    (ra == sar_pkg::REG_GPIO_CFG) ? rd_gpio :
    (ra == sar_pkg::REG_STATUS) ? rd_sts : 32'h0;
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sar_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_have_d & ~bvalid_d;
      s_axi_wready <= ~w_have_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (do_wr) begin
        s_axi_bresp <= wr_hit ? sar_pkg::RESP_OKAY : sar_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sar_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? sar_pkg::RESP_OKAY : sar_pkg::RESP_SLVERR;
      end
    end
  end

  // Control registers; the strap is taken once the synchroniser is full
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= sar_pkg::CFG_RESET;
      path_q <= sar_pkg::PATH_RESET;
      gpio_q <= sar_pkg::GPIO_RESET;
      sts_q <= '0;
      strap_cnt_q <= '0;
    end else begin
      if (strap_cnt_q != sar_pkg::STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      if (wr_cfg) begin
        cfg_q <= cfg_wr[sar_pkg::CFG_W-1:0];
      end else if (strap_load) begin
        cfg_q[sar_pkg::CFG_SPLIT] <= strap_s;
      end
      if (wr_path) begin
        path_q <= path_wr[sar_pkg::PATH_W-1:0];
      end
      if (wr_gpio) begin
        gpio_q <= gpio_wr[3:0];
      end
      sts_q <= (sts_q & ~sts_clr) | sts_set;
    end
  end

endmodule
`default_nettype wire

// file: sar_pkg.sv
/*
  Shared constants and types of the serial audio ingest and routing block:
  register map, field positions, reset values, timing figures, item layout.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package sar_pkg;

  // Clock and bit clock limits
  localparam int unsigned MCLK_HZ = 250_000_000;
  localparam int unsigned BCLK_MIN_HZ = 1_000_000;
  localparam int unsigned BCLK_MAX_HZ = 13_000_000;
  // Shortest legal bit clock period, rounded down so jitter is tolerated
  localparam int unsigned BCLK_MIN_CYC_I = MCLK_HZ / BCLK_MAX_HZ;
  // Longest legal bit clock period, rounded down
  localparam int unsigned BCLK_MAX_CYC_I = MCLK_HZ / BCLK_MIN_HZ;
  localparam int PER_W = 9;
  localparam logic [PER_W-1:0] BCLK_MIN_CYC = PER_W'(BCLK_MIN_CYC_I);
  localparam logic [PER_W-1:0] BCLK_MAX_CYC = PER_W'(BCLK_MAX_CYC_I);

  // Strap sampling waits for the pin synchroniser to fill
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_AUDIO_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PATH_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GPIO_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Audio configuration fields
  localparam int CFG_SPLIT = 0;
  localparam int CFG_WL_LO = 1;
  localparam int CFG_TDM = 3;
  localparam int CFG_TDM8 = 4;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h04;
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_24 = 2'h1;

  // Link path control fields
  localparam int PATH_DI_OFF = 0;
  localparam int PATH_MODE_LO = 1;
  localparam int PATH_LEGACY = 3;
  localparam int PATH_W = 4;
  localparam logic [PATH_W-1:0] PATH_RESET = 4'h0;
  localparam logic [1:0] CH_STEREO = 2'h0;
  localparam logic [1:0] CH_FOUR = 2'h1;
  localparam logic [1:0] CH_SURROUND = 2'h2;

  // Register-GPIO control and pin readback
  localparam int GPIO_LVL_LO = 8;
  localparam logic [3:0] GPIO_RESET = 4'h0;

  // Status bits, write one to clear where sticky
  localparam int ST_SLOW = 0;
  localparam int ST_FAST = 1;
  localparam int ST_OVR = 2;
  localparam int ST_DI = 4;
  localparam int ST_SURR = 5;
  localparam int ST_W = 3;

  // Lane masks
  localparam logic [3:0] LANES_A = 4'h1;
  localparam logic [3:0] LANES_AB = 4'h3;
  localparam logic [3:0] LANES_ALL = 4'hF;

  // Time-division slots
  localparam int TDM_POS_W = 8;
  localparam logic [4:0] SLOT32_LAST = 5'h1F;
  localparam logic [5:0] SLOT64_LAST = 6'h3F;

  typedef struct packed {
    logic [1:0] lane_p0;
    logic [1:0] lane_p1;
    logic [2:0] chan;
    logic encrypt;
    logic [31:0] data;
  } sar_item_type;

  localparam int ITEM_W = $bits(sar_item_type);

endpackage

// file: sar_skid.sv
/*
  Two-entry buffer with valid and ready on both sides; every output is a
  flip-flop. Assumes source and sink run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sar_skid (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire sar_pkg::sar_item_type in_item,
  output logic out_valid,
  input wire logic out_ready,
  output sar_pkg::sar_item_type out_item
);

  logic skid_valid_q;
  sar_pkg::sar_item_type skid_q;
  wire logic in_take = in_valid & in_ready;
  wire logic out_take = out_valid & out_ready;
  wire logic out_free = ~out_valid | out_ready;

  // Second entry catches the word that arrives while the sink stalls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      skid_valid_q <= 1'b0;
      in_ready <= 1'b0;
      out_item <= '0;
      skid_q <= '0;
    end else begin
      if (out_free) begin
        out_valid <= skid_valid_q | in_take;
        out_item <= skid_valid_q ? skid_q : in_item;
        skid_valid_q <= skid_valid_q & in_take;
        if (skid_valid_q) begin
          skid_q <= in_item;
        end
      end else if (in_take) begin
        skid_valid_q <= 1'b1;
        skid_q <= in_item;
      end
      in_ready <= ~((skid_valid_q | in_take) & ~out_free) &
                  ~(skid_valid_q & in_take & out_free & ~out_take);
    end
  end

endmodule
`default_nettype wire

// file: sar_top_monitor.sv
/* Checker of the serial audio ingest block, bound to sar_top.
   Sees top-level ports only; clock mclk, reset rst_b active low. */
`timescale 1ns/1ns
`default_nettype none
module sar_top_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic video_blanking,
  input wire logic content_protect_active,
  input wire logic audio_valid,
  input wire logic audio_ready,
  input wire sar_pkg::sar_item_type audio_item
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write answer missing");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_returns: assert property (
    s_axi_bvalid && s_axi_bready |-> ##[1:2] s_axi_awready)
    else $error("write ready not back");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_rdata_stands: assert property (
    s_axi_rvalid && $past(s_axi_rvalid && !s_axi_rready)
    |-> $stable(s_axi_rdata)) else $error("read data changed");
  a_item_stands: assert property (
    audio_valid && !audio_ready |=> audio_valid && $stable(audio_item))
    else $error("audio item changed while stalled");
  a_di_blank: assert property (
    audio_valid && audio_ready && audio_item.encrypt |-> video_blanking)
    else $error("island item outside blanking");
  a_enc_cause: assert property (
    audio_valid && audio_item.encrypt |-> content_protect_active)
    else $error("encrypt without protection");
  a_frame_lanes: assert property (
    audio_valid && audio_ready && !video_blanking
    |-> audio_item.lane_p0 <= 2'h1 && !audio_item.encrypt)
    else $error("frame-bit item on wrong lane");
  a_port1_map: assert property (
    audio_valid
    |-> (audio_item.lane_p1 ^ audio_item.lane_p0) inside {2'h0, 2'h2})
    else $error("port 1 lane mapping wrong");
  a_tdm_lane: assert property (
    audio_valid && audio_item.chan > 3'h1 |-> audio_item.lane_p0 == 2'h0)
    else $error("slot word not on lane A");
endmodule
bind sar_top sar_top_monitor i_mon (.*);
`default_nettype wire

// file: sar_audio_src.sv
/* Behavioural audio source: bit clock, word select and four data lines.
   Assumes the bench calls one frame task at a time. */
`timescale 1ns/1ns
`default_nettype none
module sar_audio_src (
  output logic audio_bit_clock_in,
  output logic audio_word_select_in,
  output logic audio_data_line_a,
  output logic audio_data_line_b,
  output logic audio_data_line_c,
  output logic audio_data_line_d
);
  // 80 ns period: a 12.5 MHz bit clock, inside the legal window
  localparam time HALF = 40;
  logic [3:0] sd;
  assign {audio_data_line_d, audio_data_line_c, audio_data_line_b,
    audio_data_line_a} = sd;
  initial begin
    audio_bit_clock_in = 1'b0;
    audio_word_select_in = 1'b0;
    sd = 4'h0;
  end
  // Lines move while the clock is low, so the rising edge sees them settled
  task automatic put(input logic w, input logic [3:0] d);
    audio_word_select_in = w;
    sd = d;
    #HALF audio_bit_clock_in = 1'b1;
    #HALF audio_bit_clock_in = 1'b0;
  endtask
  // Word select flips with the last bit of each word, low for left
  task automatic stereo(input logic [3:0][31:0] l, r);
    logic [3:0] d;
    for (int i = 0; i < 64; i++) begin
      for (int k = 0; k < 4; k++)
        d[k] = i < 32 ? l[k][31 - i] : r[k][63 - i];
      put(i % 32 == 31 ? i < 32 : i >= 32, d);
    end
    // Clock stops between frames; stale bits must not look valid
    sd = ~d;
  endtask
  task automatic tdm(input logic [7:0][31:0] s);
    put(1'b1, ~sd);
    for (int i = 0; i < 256; i++)
      put(1'b0, {3'h0, s[i / 32][31 - i % 32]});
    sd = ~sd;
  endtask
endmodule
`default_nettype wire

// file: sar_top_tb.sv
/* Self-checking bench of the serial audio ingest block.
   Assumes the source model and the bound checker are compiled with it. */
`timescale 1ns/1ns
`default_nettype none
module sar_top_tb;
  logic mclk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, audio_valid, audio_ready;
  logic splitter_strap, video_blanking, content_protect_active;
  logic upstream_surround, audio_bit_clock_in, audio_word_select_in;
  logic audio_data_line_a, audio_data_line_b;
  logic audio_data_line_c, audio_data_line_d;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0][31:0] s;
  sar_pkg::sar_item_type audio_item, exp_q[$];
  int n_fail, n_checks;
  sar_top i_dut (.*);
  sar_audio_src i_src (.*);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_item(input sar_pkg::sar_item_type g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw, w;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {aw, w} = 2'h0;
    while (!(aw && w)) begin
      @(posedge mclk);
      aw |= s_axi_awvalid & s_axi_awready;
      w |= s_axi_wvalid & s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp_word(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp_word(s_axi_rdata, ed);
    cmp_word(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic drain;
    repeat (400) if (exp_q.size() != 0) @(posedge mclk);
    cmp_word(32'(exp_q.size()), 32'h0);
  endtask
  // Random receiver stalls exercise the two-entry buffer
  always @(posedge mclk) begin
    if (rst_b && audio_valid && audio_ready)
      cmp_item(audio_item, exp_q.size() ? exp_q.pop_front() : 'x);
    audio_ready <= 1'($urandom);
  end
  task automatic run(input logic [7:0] cfg, path, gpio,
    input logic ups, pr, blank, input logic [3:0] lanes);
    logic [3:0][31:0] l, r;
    logic [31:0] m;
    l = {$urandom, $urandom, $urandom, $urandom};
    r = {$urandom, $urandom, $urandom, $urandom};
    m = cfg[2:1] == sar_pkg::WL_16 ? 32'hFFFF :
      cfg[2:1] == sar_pkg::WL_24 ? 32'hFF_FFFF : 32'hFFFF_FFFF;
    axw(sar_pkg::REG_AUDIO_CFG, 32'(cfg), sar_pkg::RESP_OKAY);
    axr(sar_pkg::REG_AUDIO_CFG, 32'(cfg), sar_pkg::RESP_OKAY);
    axw(sar_pkg::REG_PATH_CTL, 32'(path), sar_pkg::RESP_OKAY);
    axw(sar_pkg::REG_GPIO_CFG, 32'(gpio), sar_pkg::RESP_OKAY);
    upstream_surround <= ups;
    content_protect_active <= pr;
    video_blanking <= blank;
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
        if (lanes[k])
          exp_q.push_back({2'(k), 2'(cfg[0] ? k ^ 2 : k), 3'(c),
            pr & !path[0], (c ? r[k] : l[k]) & m});
    #1 i_src.stereo(l, r);
    repeat (40) @(posedge mclk);
    if (!blank)
      cmp_word(32'(exp_q.size()),
        path[0] ? 32'h0 : 32'(2 * $countones(lanes)));
    video_blanking <= 1'b1;
    drain;
  endtask
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, video_blanking} = '0;
    {content_protect_active, upstream_surround} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    splitter_strap = 1'b1;
    void'($urandom(32'hD022));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    axr(sar_pkg::REG_AUDIO_CFG, 32'(sar_pkg::CFG_RESET) | 32'h1,
      sar_pkg::RESP_OKAY);
    axr(sar_pkg::REG_PATH_CTL, 32'h0, sar_pkg::RESP_OKAY);
    axr(8'h10, 32'h0, sar_pkg::RESP_SLVERR);
    axw(8'h10, 32'hFFFF_FFFF, sar_pkg::RESP_SLVERR);
    run(8'h04, 8'h00, 8'h0, 1'b0, 1'b1, 1'b0, 4'h1);
    run(8'h05, 8'h04, 8'h0, 1'b0, 1'b0, 1'b1, 4'hF);
    run(8'h05, 8'h00, 8'h0, 1'b1, 1'b1, 1'b1, 4'hF);
    run(8'h04, 8'h0D, 8'h0, 1'b0, 1'b1, 1'b0, 4'h3);
    run(8'h04, 8'h01, 8'h0, 1'b1, 1'b0, 1'b0, 4'h1);
    run(8'h00, 8'h02, 8'h2, 1'b0, 1'b1, 1'b1, 4'h1);
    run(8'h02, 8'h02, 8'h0, 1'b0, 1'b0, 1'b1, 4'h3);
    axw(sar_pkg::REG_AUDIO_CFG, 32'h1C, sar_pkg::RESP_OKAY);
    axw(sar_pkg::REG_PATH_CTL, 32'h0, sar_pkg::RESP_OKAY);
    content_protect_active <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      s[k] = $urandom;
      exp_q.push_back({4'h0, 3'(k), 1'b0, s[k]});
    end
    #1 i_src.tdm(s);
    drain;
    axw(sar_pkg::REG_AUDIO_CFG, 32'h0C, sar_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++)
      exp_q.push_back({4'h0, 3'(k), 1'b0, s[2 * k]});
    #1 i_src.tdm(s);
    drain;
    tally_and_finish;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
